// ==== hw/pmt_params.svh ====
// Register indices, field positions, reset values and timing constants of the period match timer.
`ifndef PMT_PARAMS_SVH
`define PMT_PARAMS_SVH

`define PMT_ADDR_COUNT      2'h0
`define PMT_ADDR_PERIOD     2'h1
`define PMT_ADDR_CONTROL    2'h2
`define PMT_ADDR_FLAG       2'h3

`define PMT_CTRL_PRE_LSB    0
`define PMT_CTRL_PRE_MSB    1
`define PMT_CTRL_RUN_BIT    2
`define PMT_CTRL_POST_LSB   3
`define PMT_CTRL_POST_MSB   6
`define PMT_CTRL_WMASK      8'h7F
`define PMT_FLAG_MATCH_BIT  1

`define PMT_COUNT_RESET     8'h00
`define PMT_PERIOD_RESET    8'hFF
`define PMT_CONTROL_RESET   8'h00
`define PMT_BYTE_ZERO       8'h00

`define PMT_PRE_DIV1        2'h0
`define PMT_PRE_DIV4        2'h1
`define PMT_PRE_LAST1       4'h0
`define PMT_PRE_LAST4       4'h3
`define PMT_PRE_LAST16      4'hF
`define PMT_PRE_ZERO        4'h0
`define PMT_PRE_ONE         4'h1
`define PMT_QUARTER_DIV     2'h3
`define PMT_QUARTER_ZERO    2'h0
`define PMT_QUARTER_ONE     2'h1
`define PMT_POST_ZERO       4'h0
`define PMT_POST_ONE        4'h1
`define PMT_COUNT_ONE       8'h01

`endif

// ==== hw/pmt_pkg.sv ====
// Types shared by the period match timer modules.
package pmt_pkg;
    typedef enum logic [1:0] {
        PMT_PRE_1,
        PMT_PRE_4,
        PMT_PRE_16
    } pmt_prescale_t;
endpackage

// ==== hw/pmt_tick_if.sv ====
// Tick and clear signals passed between the timer core and its scaler modules.
`timescale 1ns/1ns
`default_nettype none
interface pmt_tick_if;
    logic       tick;
    logic       clear;
    logic [3:0] last;
    logic       done;
    modport owner (output tick, output clear, output last, input done);
    modport scaler (input tick, input clear, input last, output done);
endinterface
`default_nettype wire

// ==== hw/pmt_scaler.sv ====
// Divide-by-N event counter used for both the prescaler and the postscaler.
`timescale 1ns/1ns
`default_nettype none
`include "pmt_params.svh"
module pmt_scaler (
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    pmt_tick_if.scaler  tick_port
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // Emits done on the tick that completes last+1 input ticks.
    always_comb
    begin
        cnt_next = cnt_reg;
        tick_port.done = 1'b0;
        if (tick_port.clear)
        begin
            cnt_next = `PMT_PRE_ZERO;
        end
        else if (tick_port.tick)
        begin
            if (cnt_reg >= tick_port.last)
            begin
                cnt_next = `PMT_PRE_ZERO;
                tick_port.done = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg + `PMT_PRE_ONE;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            cnt_reg <= `PMT_PRE_ZERO;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// ==== hw/pmt_timer.sv ====
// Period match timer: 8-bit counter with prescaler, period register and postscaler.
// What this block does
// RULE_01 - 8-bit count and period registers, both readable and writable by software.
// RULE_02 - Counter clock is system clock over four, then prescaled 1, 4 or 16.
// RULE_03 - Control bits 1:0 pick prescale: 00 gives 1, 01 gives 4, 1x gives 16.
// RULE_04 - Control bits 6:3 pick postscale linearly, 0000 is 1:1, 1111 is 1:16.
// RULE_05 - Matches pass the postscaler; its completion sets match flag, flag bit 1.
// RULE_06 - Control bit 2 runs the timer when set, stops it when clear.
// RULE_07 - Every reset clears the count register.
// RULE_08 - Count write, control write or reset clears prescaler and postscaler.
// RULE_09 - Writing control leaves the count value unchanged.
// RULE_10 - Control bit 7 is unimplemented and reads zero.
// RULE_11 - The period match event is offered to the PWM unit as time base.
// RULE_12 - PWM period is four clocks times period plus one times prescale.
// RULE_13 - Count increments until equal to period, next tick returns to zero with match.
// RULE_14 - Control resets to zero: timer off, prescale 1, postscale 1:1.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "pmt_params.svh"
module pmt_timer (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [1:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    output logic            o_period_match,
    output logic            o_match_flag
);
    logic [7:0]  count_value_reg;
    logic [7:0]  count_value_next;
    logic [7:0]  period_value_reg;
    logic [7:0]  period_value_next;
    logic [6:0]  timer_control_reg;
    logic [6:0]  timer_control_next;
    logic        match_flag_reg;
    logic        match_flag_next;
    logic [1:0]  quarter_reg;
    logic [1:0]  quarter_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        match_reg;
    logic        match_next;
    logic        timer_run;
    logic        wr_count;
    logic        wr_period;
    logic        wr_control;
    logic        wr_flag;
    logic        quarter_tick;
    logic        count_tick;
    logic        match_event;
    logic        scaler_clear;
    pmt_pkg::pmt_prescale_t pre_divide_select;

    pmt_tick_if pre_if ();
    pmt_tick_if post_if ();

    assign wr_count   = i_wr && (i_addr == `PMT_ADDR_COUNT);
    assign wr_period  = i_wr && (i_addr == `PMT_ADDR_PERIOD);
    assign wr_control = i_wr && (i_addr == `PMT_ADDR_CONTROL);
    assign wr_flag    = i_wr && (i_addr == `PMT_ADDR_FLAG);
    assign timer_run  = timer_control_reg[`PMT_CTRL_RUN_BIT];              // [RULE_06]
    assign scaler_clear = wr_count || wr_control;                           // [RULE_08]

    // Prescale select decode; both 1x codes map to divide by 16.
    always_comb
    begin
        unique case (timer_control_reg[`PMT_CTRL_PRE_MSB:`PMT_CTRL_PRE_LSB])
            `PMT_PRE_DIV1: pre_divide_select = pmt_pkg::PMT_PRE_1;          // [RULE_03]
            `PMT_PRE_DIV4: pre_divide_select = pmt_pkg::PMT_PRE_4;          // [RULE_03]
            default:       pre_divide_select = pmt_pkg::PMT_PRE_16;         // [RULE_03]
        endcase
    end

    always_comb
    begin
        unique case (pre_divide_select)
            pmt_pkg::PMT_PRE_1:  pre_if.last = `PMT_PRE_LAST1;              // [RULE_02]
            pmt_pkg::PMT_PRE_4:  pre_if.last = `PMT_PRE_LAST4;              // [RULE_02]
            pmt_pkg::PMT_PRE_16: pre_if.last = `PMT_PRE_LAST16;             // [RULE_02]
        endcase
    end

    // The instruction clock is one system clock in four.
    assign quarter_tick = timer_run && (quarter_reg == `PMT_QUARTER_DIV);  // [RULE_02]
    assign pre_if.tick  = quarter_tick;
    assign pre_if.clear = scaler_clear;
    assign count_tick   = pre_if.done;

    pmt_scaler u_prescaler (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .tick_port (pre_if)
    );

    // Match is taken on the tick after count equals period.
    assign match_event = count_tick && (count_value_reg == period_value_reg); // [RULE_13]

    assign post_if.tick  = match_event;                                     // [RULE_05]
    assign post_if.clear = scaler_clear;                                    // [RULE_08]
    assign post_if.last  = timer_control_reg[`PMT_CTRL_POST_MSB:`PMT_CTRL_POST_LSB]; // [RULE_04]

    pmt_scaler u_postscaler (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .tick_port (post_if)
    );

    always_comb
    begin
        quarter_next = quarter_reg;
        if (scaler_clear || !timer_run)
        begin
            quarter_next = `PMT_QUARTER_ZERO;
        end
        else
        begin
            quarter_next = quarter_reg + `PMT_QUARTER_ONE;
        end
    end

    always_comb
    begin
        count_value_next = count_value_reg;
        if (wr_count)
        begin
            count_value_next = i_wdata;                                     // [RULE_01]
        end
        else if (match_event)
        begin
            count_value_next = `PMT_COUNT_RESET;                            // [RULE_13]
        end
        else if (count_tick)
        begin
            count_value_next = count_value_reg + `PMT_COUNT_ONE;            // [RULE_13]
        end
    end

    always_comb
    begin
        period_value_next = period_value_reg;
        if (wr_period)
        begin
            period_value_next = i_wdata;                                    // [RULE_01]
        end
    end

    always_comb
    begin
        timer_control_next = timer_control_reg;
        if (wr_control)
        begin
            timer_control_next = i_wdata[6:0];                              // [RULE_09]
        end
    end

    // Set wins over a software clear in the same cycle.
    always_comb
    begin
        match_flag_next = match_flag_reg;
        if (wr_flag && !i_wdata[`PMT_FLAG_MATCH_BIT])
        begin
            match_flag_next = 1'b0;
        end
        if (post_if.done)
        begin
            match_flag_next = 1'b1;                                         // [RULE_05]
        end
    end

    assign match_next = match_event;                                        // [RULE_11] [RULE_12]

    always_comb
    begin
        rdata_next = `PMT_BYTE_ZERO;
        if (i_rd)
        begin
            unique case (i_addr)
                `PMT_ADDR_COUNT:   rdata_next = count_value_reg;            // [RULE_01]
                `PMT_ADDR_PERIOD:  rdata_next = period_value_reg;           // [RULE_01]
                `PMT_ADDR_CONTROL: rdata_next = {1'b0, timer_control_reg};  // [RULE_10]
                `PMT_ADDR_FLAG:    rdata_next = {6'h00, match_flag_reg, 1'b0};
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            count_value_reg   <= `PMT_COUNT_RESET;                          // [RULE_07]
            period_value_reg  <= `PMT_PERIOD_RESET;
            timer_control_reg <= 7'(`PMT_CONTROL_RESET);                    // [RULE_14]
            match_flag_reg    <= 1'b0;
            quarter_reg       <= `PMT_QUARTER_ZERO;
            rdata_reg         <= `PMT_BYTE_ZERO;
            match_reg         <= 1'b0;
        end
        else
        begin
            count_value_reg   <= count_value_next;
            period_value_reg  <= period_value_next;
            timer_control_reg <= timer_control_next;
            match_flag_reg    <= match_flag_next;
            quarter_reg       <= quarter_next;
            rdata_reg         <= rdata_next;
            match_reg         <= match_next;
        end
    end

    assign o_rdata        = rdata_reg;
    assign o_period_match = match_reg;
    assign o_match_flag   = match_flag_reg;
endmodule
`default_nettype wire

// ==== verif/pmt_timer_sva.sv ====
// Port checker for the period match timer.
`timescale 1ns/1ns
`default_nettype none
module pmt_timer_sva (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       o_period_match,
    input wire logic       o_match_flag
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_ctl_top; $past(i_rd) && $past(i_addr) == 2'h2 |-> !o_rdata[7]; endproperty
    a_ctl_top: assert property (p_ctl_top) else $error("control top bit read as one");
    property p_cnt_rw; (i_wr && i_addr == 2'h0) ##1 (i_rd && i_addr == 2'h0)
        |=> o_rdata == $past(i_wdata, 2); endproperty
    a_cnt_rw: assert property (p_cnt_rw) else $error("count read back differs");
    property p_per_rw; (i_wr && i_addr == 2'h1) ##1 (i_rd && i_addr == 2'h1)
        |=> o_rdata == $past(i_wdata, 2); endproperty
    a_per_rw: assert property (p_per_rw) else $error("period read back differs");
    property p_ctl_rw; (i_wr && i_addr == 2'h2) ##1 (i_rd && i_addr == 2'h2)
        |=> o_rdata == ($past(i_wdata, 2) & 8'h7F); endproperty
    a_ctl_rw: assert property (p_ctl_rw) else $error("control read back differs");
    property p_gap; o_period_match |=> !o_period_match [*3]; endproperty
    a_gap: assert property (p_gap) else $error("match events too close");
    property p_hold; o_match_flag && !(i_wr && i_addr == 2'h3 && !i_wdata[1])
        |=> o_match_flag; endproperty
    a_hold: assert property (p_hold) else $error("match flag dropped");
    property p_cause; $rose(o_match_flag) |-> o_period_match || $past(o_period_match); endproperty
    a_cause: assert property (p_cause) else $error("flag set without match");
    property p_stop; (i_wr && i_addr == 2'h2 && !i_wdata[2]) ##1 !(i_wr && i_addr == 2'h2) [*4]
        |-> !o_period_match [*5]; endproperty
    a_stop: assert property (p_stop) else $error("match while stopped");
    property p_rst; disable iff (1'b0) i_rst |=> !o_period_match && !o_match_flag; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind pmt_timer pmt_timer_sva u_pmt_timer_sva (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_period_match(o_period_match), .o_match_flag(o_match_flag));
`default_nettype wire

// ==== verif/pmt_timer_bench.sv ====
// Self-checking bench for the period match timer.
`timescale 1ns/1ns
`default_nettype none
module pmt_timer_bench;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic       o_period_match;
    logic       o_match_flag;
    logic       rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] rv;
    int         fails = 0;
    int         checks_done = 0;
    int         n;
    int         d1;

    pmt_timer u_pmt_timer (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_period_match(o_period_match),
        .o_match_flag(o_match_flag));

    initial
        forever #5 i_clk = ~i_clk;

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One bus cycle; on a read the data argument is the expected answer.
    task automatic bus(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
        i_wr    <= w;
        i_rd    <= r;
        i_addr  <= a;
        i_wdata <= d;
        if (r)
            exp_q.push_back(d);
        @(posedge i_clk);
    endtask

    // Counts clock edges until the next match event, with a bound.
    task automatic gap(output int c);
        c = 0;
        do
        begin
            @(posedge i_clk);
            c++;
        end while (o_period_match !== 1'b1 && c < 5000);
    endtask

    always @(posedge i_clk)
        rd_seen <= i_rd;

    always @(negedge i_clk)
        if (rd_seen)
            check({8'h00, o_rdata}, {8'h00, exp_q.pop_front()});

    initial
    begin
        #200000;
        fails++;
        end_of_test();
    end

    initial
    begin
        void'($urandom(32'h79b9_e3ed));
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        bus(0, 1, 2'h0, 8'h00);
        bus(0, 1, 2'h1, 8'hFF);
        bus(0, 1, 2'h2, 8'h00);
        bus(0, 1, 2'h3, 8'h00);
        repeat (4)
        begin
            rv = 8'($urandom);
            bus(1, 0, 2'h1, rv);
            bus(0, 1, 2'h1, rv);
            bus(1, 0, 2'h0, ~rv);
            bus(0, 1, 2'h0, ~rv);
            bus(1, 0, 2'h2, (rv | 8'h80) & 8'hFB);
            bus(0, 1, 2'h2, rv & 8'h7B);
            bus(0, 1, 2'h0, ~rv);
        end
        for (int k = 0; k < 4; k++)
        begin
            bus(1, 0, 2'h1, 8'h02);
            bus(1, 0, 2'h0, 8'h00);
            bus(1, 0, 2'h2, 8'(k) | 8'h04);
            bus(0, 0, 2'h0, 8'h00);
            gap(d1);
            gap(n);
            check(16'(n), 16'(12 << (2 * (k > 1 ? 2 : k))));
            repeat (20) @(posedge i_clk);
            bus(1, 0, 2'h0, 8'h00);
            bus(0, 0, 2'h0, 8'h00);
            gap(n);
            check(16'(n), 16'(d1));
        end
        for (int p = 0; p < 16; p += 5)
        begin
            bus(1, 0, 2'h2, 8'h00);
            bus(1, 0, 2'h1, 8'h00);
            bus(1, 0, 2'h0, 8'h00);
            bus(1, 0, 2'h3, 8'h00);
            bus(1, 0, 2'h2, 8'(p << 3) | 8'h04);
            bus(0, 0, 2'h0, 8'h00);
            n = 0;
            for (int c = 0; c < 400 && o_match_flag !== 1'b1; c++)
            begin
                @(posedge i_clk);
                n += int'(o_period_match === 1'b1);
            end
            check(16'(n), 16'(p + 1));
            bus(0, 1, 2'h3, 8'h02);
            bus(1, 0, 2'h3, 8'h00);
            bus(0, 1, 2'h3, 8'h00);
        end
        bus(1, 0, 2'h2, 8'h00);
        bus(0, 0, 2'h0, 8'h00);
        repeat (2) @(posedge i_clk);
        n = 0;
        repeat (64)
        begin
            @(posedge i_clk);
            n += int'(o_period_match === 1'b1);
        end
        check(16'(n), 16'h0000);
        end_of_test();
    end
endmodule
`default_nettype wire
